/* File: rtl/tpc_perf_irq_status.sv */
// Receive performance counters and clear-on-read event status words for a T1 framer.
// Assumes event inputs are produced by framer logic on ref_clk; only the analog loss input is asynchronous.
//
// Contract
// - Count multiframes that saw frame sync lost.
// - Sixteen-bit bipolar violation counter, two byte addresses.
// - Sixteen-bit CRC error counter, high then low.
// - Word zero bit 7: frame sync change.
// - Word zero bit 6: multiframe sync change.
// - Word zero bit 4: all-ones change; bit 5 unused.
// - Word zero bit 3: signal loss change.
// - Word zero bit 2: two framing errors in six.
// - Word zero bit 1: transmit buffer slip.
// - Word zero bit 0: receive buffer slip.
// - Reading a status word clears its bits.
// - Masked events leave status bits low.
// - Word one bit 7: framing bit error in sync.
// - Word one bit 6: CRC check failure.
// - Word one bit 5: yellow alarm detected.
// - Word one bit 4: alignment shifted after reframe.
// - Word one bit 3: bipolar violation, B8ZS excluded.
// - Word one bit 2: PRBS error; bit 0 unused.
// - No B8ZS: sixteen zeros or low density.
// - With B8ZS: eight consecutive zeros.
// - Counters wrap from all ones to zero.
`timescale 1ns/10ps

module tpc_perf_irq_status (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   input  wire logic       frameSyncIn,
   input  wire logic       mfSyncIn,
   input  wire logic       allOnesIn,
   input  wire logic       analogLosIn,
   input  wire logic       mfBoundaryIn,
   input  wire logic       fbitValidIn,
   input  wire logic       fbitErrIn,
   input  wire logic       bpvIn,
   input  wire logic       bpvB8zsIn,
   input  wire logic       crcErrIn,
   input  wire logic       yellowIn,
   input  wire logic       cofaIn,
   input  wire logic       prbsErrIn,
   input  wire logic       txSlipIn,
   input  wire logic       rxSlipIn,
   input  wire logic       rxBitEnIn,
   input  wire logic       rxBitIn
);

   // Byte address of a register index.
   function automatic logic [7:0] tpc_adr(input logic [7:0] idx);
      tpc_adr = {idx[5:0], 2'b00};
   endfunction : tpc_adr

   // Saturating increment of a line age.
   function automatic logic [7:0] tpc_age_inc(input logic [7:0] age);
      tpc_age_inc = (age == tpc_pkg::AGE_MAX) ? age : age + 8'h01;
   endfunction : tpc_age_inc

   logic [7:0]  rdData_ff;
   logic [7:0]  mfCnt_ff;
   logic [15:0] bpvCnt_ff;
   logic [15:0] crcCnt_ff;
   logic [7:0]  ev0Flags_ff;
   logic [7:0]  ev1Flags_ff;
   logic [7:0]  mask0_ff;
   logic [7:0]  mask1_ff;
   logic [7:0]  ctrl_ff;
   logic        mfLost_ff;
   logic        fsPrev_ff;
   logic        mfsPrev_ff;
   logic        aisPrev_ff;
   logic        losPrev_ff;
   logic        losMeta1_ff;
   logic        losMeta2_ff;
   logic        losMeta3_ff;
   logic        losAnalog_ff;
   logic [4:0]  fbitHist_ff;
   logic [7:0]  zeroRun_ff;
   logic [7:0]  oneAge_ff [0:tpc_pkg::DENS_ONES_MAX-1];

   // Address decode.
   wire         hitMf    = (regAddr == tpc_adr(tpc_pkg::IDX_MF_SYNC_LOSS));
   wire         hitBpvH  = (regAddr == tpc_adr(tpc_pkg::IDX_BPV_HI));
   wire         hitBpvL  = (regAddr == tpc_adr(tpc_pkg::IDX_BPV_LO));
   wire         hitCrcH  = (regAddr == tpc_adr(tpc_pkg::IDX_CRC_HI));
   wire         hitCrcL  = (regAddr == tpc_adr(tpc_pkg::IDX_CRC_LO));
   wire         hitEv0   = (regAddr == tpc_adr(tpc_pkg::IDX_SYNC_SLIP_EV));
   wire         hitEv1   = (regAddr == tpc_adr(tpc_pkg::IDX_LINE_ERR_EV));
   wire         hitMsk0  = (regAddr == tpc_adr(tpc_pkg::IDX_SYNC_SLIP_MSK));
   wire         hitMsk1  = (regAddr == tpc_adr(tpc_pkg::IDX_LINE_ERR_MSK));
   wire         hitCtrl  = (regAddr == tpc_adr(tpc_pkg::IDX_LINE_CTRL));

   // Read data selection; unmapped addresses read as zero.
   wire  [7:0]  rdSel = hitMf   ? mfCnt_ff :
                        hitBpvH ? bpvCnt_ff[15:8] :
                        hitBpvL ? bpvCnt_ff[7:0] :
                        hitCrcH ? crcCnt_ff[15:8] :
                        hitCrcL ? crcCnt_ff[7:0] :
                        hitEv0  ? ev0Flags_ff :
                        hitEv1  ? ev1Flags_ff :
                        hitMsk0 ? mask0_ff :
                        hitMsk1 ? mask1_ff :
                        hitCtrl ? ctrl_ff : 8'h00;

   wire         clrEv0  = regRd & hitEv0;
   wire         clrEv1  = regRd & hitEv1;
   wire         b8zsEn  = ctrl_ff[tpc_pkg::BIT_B8ZS_EN];

   // Signal loss from the analog detector or a long zero run.
   wire         losNow  = losAnalog_ff | (zeroRun_ff >= tpc_pkg::LOS_ZERO_RUN);

   // Line zero run and pulse density.
   wire  [7:0]  nxt_zeroRun = rxBitIn ? 8'h00 : tpc_age_inc(zeroRun_ff);
   wire  [7:0]  ageNxt [0:tpc_pkg::DENS_ONES_MAX-1];
   wire  [tpc_pkg::DENS_ONES_MAX-1:0] densFail;

   genvar gi;
   generate
      for (gi = 0; gi < tpc_pkg::DENS_ONES_MAX; gi = gi + 1) begin : g_dens
         localparam logic [7:0] WIN = 8'(tpc_pkg::DENS_BITS_PER_N * (gi + 2));
         if (gi == 0) begin : g_first
            assign ageNxt[gi] = rxBitIn ? 8'h00 : tpc_age_inc(oneAge_ff[gi]);
         end else begin : g_rest
            assign ageNxt[gi] = rxBitIn ? tpc_age_inc(oneAge_ff[gi-1]) : tpc_age_inc(oneAge_ff[gi]);
         end
         assign densFail[gi] = (ageNxt[gi] >= WIN);
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               oneAge_ff[gi] <= tpc_pkg::RST_BYTE;
            end else if (rxBitEnIn) begin
               oneAge_ff[gi] <= ageNxt[gi];
            end
         end
      end
   endgenerate

   wire         pdvPlain = (nxt_zeroRun == tpc_pkg::PDV_ZERO_RUN) | (|densFail);
   wire         pdvB8zs  = (nxt_zeroRun == tpc_pkg::PDV_ZERO_RUN_B8ZS);
   wire         pdvEv    = rxBitEnIn & (b8zsEn ? pdvB8zs : pdvPlain);

   // Severely errored framing: this error plus one among the previous five.
   wire         sefEv    = fbitValidIn & fbitErrIn & (|fbitHist_ff);
   wire         bpvReal  = bpvIn & ~bpvB8zsIn;
   wire         mfInc    = mfBoundaryIn & (mfLost_ff | ~frameSyncIn);

   // Raw events for each status word.
   wire  [7:0]  ev0 = {frameSyncIn ^ fsPrev_ff,
                       mfSyncIn ^ mfsPrev_ff,
                       1'b0,
                       allOnesIn ^ aisPrev_ff,
                       losNow ^ losPrev_ff,
                       sefEv,
                       txSlipIn,
                       rxSlipIn};
   wire  [7:0]  ev1 = {fbitValidIn & fbitErrIn & frameSyncIn,
                       crcErrIn,
                       yellowIn,
                       cofaIn,
                       bpvReal,
                       prbsErrIn,
                       pdvEv,
                       1'b0};

   // Sticky flags: a gated event wins over the read clear in the same cycle.
   wire  [7:0]  nxt_ev0Flags = (ev0Flags_ff & ~{8{clrEv0}}) | (ev0 & mask0_ff);
   wire  [7:0]  nxt_ev1Flags = (ev1Flags_ff & ~{8{clrEv1}}) | (ev1 & mask1_ff);

   assign regRdData = rdData_ff;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdData_ff   <= tpc_pkg::RST_BYTE;
         mask0_ff    <= tpc_pkg::RST_MASK;
         mask1_ff    <= tpc_pkg::RST_MASK;
         ctrl_ff     <= tpc_pkg::RST_BYTE;
         ev0Flags_ff <= tpc_pkg::RST_BYTE;
         ev1Flags_ff <= tpc_pkg::RST_BYTE;
      end else begin
         rdData_ff   <= regRd ? rdSel : 8'h00;
         ev0Flags_ff <= nxt_ev0Flags;
         ev1Flags_ff <= nxt_ev1Flags;
         if (regWr && hitMsk0) begin
            mask0_ff <= regWrData;
         end
         if (regWr && hitMsk1) begin
            mask1_ff <= regWrData;
         end
         if (regWr && hitCtrl) begin
            ctrl_ff <= regWrData & 8'h01;
         end
      end
   end

   // Counters wrap naturally from all ones to zero.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mfCnt_ff  <= tpc_pkg::RST_BYTE;
         bpvCnt_ff <= tpc_pkg::RST_WORD;
         crcCnt_ff <= tpc_pkg::RST_WORD;
         mfLost_ff <= 1'b0;
      end else begin
         if (mfInc) begin
            mfCnt_ff <= mfCnt_ff + 8'h01;
         end
         if (bpvReal) begin
            bpvCnt_ff <= bpvCnt_ff + 16'h0001;
         end
         if (crcErrIn) begin
            crcCnt_ff <= crcCnt_ff + 16'h0001;
         end
         mfLost_ff <= mfBoundaryIn ? 1'b0 : (mfLost_ff | ~frameSyncIn);
      end
   end

   // Previous levels for change detection and the framing error history.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fsPrev_ff   <= 1'b0;
         mfsPrev_ff  <= 1'b0;
         aisPrev_ff  <= 1'b0;
         losPrev_ff  <= 1'b0;
         fbitHist_ff <= 5'h00;
         zeroRun_ff  <= tpc_pkg::RST_BYTE;
      end else begin
         fsPrev_ff  <= frameSyncIn;
         mfsPrev_ff <= mfSyncIn;
         aisPrev_ff <= allOnesIn;
         losPrev_ff <= losNow;
         if (fbitValidIn) begin
            fbitHist_ff <= {fbitHist_ff[3:0], fbitErrIn};
         end
         if (rxBitEnIn) begin
            zeroRun_ff <= nxt_zeroRun;
         end
      end
   end

   // Analog loss detector synchroniser; a change counts once stages two and three agree.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         losMeta1_ff  <= 1'b0;
         losMeta2_ff  <= 1'b0;
         losMeta3_ff  <= 1'b0;
         losAnalog_ff <= 1'b0;
      end else begin
         losMeta1_ff <= analogLosIn;
         losMeta2_ff <= losMeta1_ff;
         losMeta3_ff <= losMeta2_ff;
         if (losMeta2_ff == losMeta3_ff) begin
            losAnalog_ff <= losMeta3_ff;
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   AST_MF_COUNT: assert property (mfBoundaryIn && !frameSyncIn |=> mfCnt_ff == $past(mfCnt_ff) + 8'h01)
      else $error("Multiframe sync loss count did not advance.");

   AST_BPV_COUNT: assert property (bpvIn && !bpvB8zsIn |=> bpvCnt_ff == $past(bpvCnt_ff) + 16'h0001)
      else $error("Bipolar violation count did not advance.");

   AST_BPV_B8ZS: assert property (bpvIn && bpvB8zsIn |=> bpvCnt_ff == $past(bpvCnt_ff))
      else $error("B8ZS code violation was counted.");

   AST_CRC_WRAP: assert property (crcErrIn && crcCnt_ff == 16'hFFFF |=> crcCnt_ff == 16'h0000)
      else $error("CRC error counter did not wrap to zero.");

   AST_CLEAR_ON_READ: assert property (regRd && hitEv1 && !(|(ev1 & mask1_ff))
                                       |=> ev1Flags_ff == 8'h00 && regRdData == $past(ev1Flags_ff))
      else $error("Status word one not returned then cleared by read.");

   AST_MASKED_LOW: assert property (mask0_ff == 8'h00 && !(regWr && hitMsk0) ##1 mask0_ff == 8'h00
                                    |-> $stable(ev0Flags_ff) || ev0Flags_ff == 8'h00)
      else $error("Masked event set a status bit.");

   AST_SET_WINS: assert property (regRd && hitEv0 && txSlipIn && mask0_ff[tpc_pkg::BIT_TX_SLIP]
                                  |=> ev0Flags_ff[tpc_pkg::BIT_TX_SLIP] ##1 1'b1)
      else $error("Slip event lost against read clear.");

   AST_STICKY: assert property (ev1Flags_ff[tpc_pkg::BIT_CRC_ERR] && !(regRd && hitEv1)
                                |=> ev1Flags_ff[tpc_pkg::BIT_CRC_ERR])
      else $error("Status bit dropped without a read.");

   AST_FBIT_IN_SYNC: assert property (fbitValidIn && fbitErrIn && !frameSyncIn
                                      && !ev1Flags_ff[tpc_pkg::BIT_FBIT_ERR] |=> !ev1Flags_ff[tpc_pkg::BIT_FBIT_ERR])
      else $error("Framing bit error flagged out of sync.");

   AST_PDV_B8ZS: assert property (rxBitEnIn && b8zsEn && nxt_zeroRun == tpc_pkg::PDV_ZERO_RUN_B8ZS
                                  && mask1_ff[tpc_pkg::BIT_PULSE_DENS]
                                  |=> ev1Flags_ff[tpc_pkg::BIT_PULSE_DENS])
      else $error("Eight zeros under B8ZS not flagged.");

   AST_FS_CHANGE: assert property ($changed(frameSyncIn) && mask0_ff[tpc_pkg::BIT_FRAME_SYNC_CHG]
                                   |=> ##1 ev0Flags_ff[tpc_pkg::BIT_FRAME_SYNC_CHG] || $past(regRd && hitEv0))
      else $error("Frame sync change not flagged.");

   AST_MFS_CHANGE: assert property ($past(rstn) && $changed(mfSyncIn)
         && mask0_ff[tpc_pkg::BIT_MF_SYNC_CHG] |=> ev0Flags_ff[tpc_pkg::BIT_MF_SYNC_CHG])
      else $error("Multiframe sync change not flagged.");

   AST_AIS_CHANGE: assert property ($past(rstn) && $changed(allOnesIn)
         && mask0_ff[tpc_pkg::BIT_ALL_ONES_CHG] |=> ev0Flags_ff[tpc_pkg::BIT_ALL_ONES_CHG])
      else $error("All-ones change not flagged.");

   AST_LOS_ZERO: assert property (rxBitEnIn && !rxBitIn && zeroRun_ff == tpc_pkg::LOS_ZERO_RUN - 8'h01
         && !losAnalog_ff && mask0_ff[tpc_pkg::BIT_SIGNAL_LOSS] && !(regWr && hitMsk0)
         |=> ##1 ev0Flags_ff[tpc_pkg::BIT_SIGNAL_LOSS])
      else $error("Zero run loss of signal not flagged.");

   AST_RX_SLIP: assert property (rxSlipIn && mask0_ff[tpc_pkg::BIT_RX_SLIP]
         |=> ev0Flags_ff[tpc_pkg::BIT_RX_SLIP])
      else $error("Receive slip not flagged.");

   AST_FBIT_FLAG: assert property (fbitValidIn && fbitErrIn && frameSyncIn
         && mask1_ff[tpc_pkg::BIT_FBIT_ERR] |=> ev1Flags_ff[tpc_pkg::BIT_FBIT_ERR])
      else $error("Framing bit error in sync not flagged.");

   AST_CRC_COUNT: assert property (crcErrIn
         |=> crcCnt_ff == $past(crcCnt_ff) + 16'h0001)
      else $error("CRC error count did not advance.");

   AST_CRC_FLAG: assert property (crcErrIn && mask1_ff[tpc_pkg::BIT_CRC_ERR]
         |=> ev1Flags_ff[tpc_pkg::BIT_CRC_ERR])
      else $error("CRC error not flagged.");

   AST_YELLOW: assert property (yellowIn && mask1_ff[tpc_pkg::BIT_YELLOW]
         |=> ev1Flags_ff[tpc_pkg::BIT_YELLOW])
      else $error("Yellow alarm not flagged.");

   AST_ALIGN: assert property (cofaIn && mask1_ff[tpc_pkg::BIT_ALIGN_SHIFT]
         |=> ev1Flags_ff[tpc_pkg::BIT_ALIGN_SHIFT])
      else $error("Alignment shift not flagged.");

   AST_BPV_FLAG: assert property (bpvIn && !bpvB8zsIn && mask1_ff[tpc_pkg::BIT_BIPOLAR]
         |=> ev1Flags_ff[tpc_pkg::BIT_BIPOLAR])
      else $error("Bipolar violation not flagged.");

   AST_PRBS: assert property (prbsErrIn && mask1_ff[tpc_pkg::BIT_PRBS]
         |=> ev1Flags_ff[tpc_pkg::BIT_PRBS])
      else $error("Test pattern error not flagged.");

   AST_PDV_RUN16: assert property (rxBitEnIn && !rxBitIn && !b8zsEn
         && zeroRun_ff == tpc_pkg::PDV_ZERO_RUN - 8'h01 && mask1_ff[tpc_pkg::BIT_PULSE_DENS]
         |=> ev1Flags_ff[tpc_pkg::BIT_PULSE_DENS])
      else $error("Sixteen zeros not flagged.");

   AST_MASKED_ONE: assert property (!mask1_ff[tpc_pkg::BIT_CRC_ERR] && !ev1Flags_ff[tpc_pkg::BIT_CRC_ERR]
         |=> !ev1Flags_ff[tpc_pkg::BIT_CRC_ERR])
      else $error("Masked CRC error set its status bit.");

   COV_READ_EV0: cover property (regRd && hitEv0 && ev0Flags_ff != 8'h00);
   COV_BPV_WRAP: cover property (bpvReal && bpvCnt_ff == 16'hFFFF);
   COV_SEVERE:   cover property (sefEv && mask0_ff[tpc_pkg::BIT_SEVERE_FRAME]);
   COV_DENSITY:  cover property (rxBitEnIn && !b8zsEn && (|densFail));
   COV_SET_WINS: cover property (regRd && hitEv0 && txSlipIn && mask0_ff[tpc_pkg::BIT_TX_SLIP]);

endmodule : tpc_perf_irq_status

/* File: rtl/tpc_pkg.sv */
// Package with the register map, field positions and counts for the receive performance counters.
// Assumes a 10 MHz ref_clk and a byte-wide register port addressed in whole words.
package tpc_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_MF_SYNC_LOSS  = 8'h15;
   localparam logic [7:0] IDX_BPV_HI        = 8'h16;
   localparam logic [7:0] IDX_BPV_LO        = 8'h17;
   localparam logic [7:0] IDX_CRC_HI        = 8'h18;
   localparam logic [7:0] IDX_CRC_LO        = 8'h19;
   localparam logic [7:0] IDX_SYNC_SLIP_EV  = 8'h1B;
   localparam logic [7:0] IDX_LINE_ERR_EV   = 8'h1C;
   localparam logic [7:0] IDX_SYNC_SLIP_MSK = 8'h2B;
   localparam logic [7:0] IDX_LINE_ERR_MSK  = 8'h2C;
   localparam logic [7:0] IDX_LINE_CTRL     = 8'h2D;

   // Status word zero bit positions.
   localparam int BIT_FRAME_SYNC_CHG = 7;
   localparam int BIT_MF_SYNC_CHG    = 6;
   localparam int BIT_ALL_ONES_CHG   = 4;
   localparam int BIT_SIGNAL_LOSS    = 3;
   localparam int BIT_SEVERE_FRAME   = 2;
   localparam int BIT_TX_SLIP        = 1;
   localparam int BIT_RX_SLIP        = 0;

   // Status word one bit positions.
   localparam int BIT_FBIT_ERR    = 7;
   localparam int BIT_CRC_ERR     = 6;
   localparam int BIT_YELLOW      = 5;
   localparam int BIT_ALIGN_SHIFT = 4;
   localparam int BIT_BIPOLAR     = 3;
   localparam int BIT_PRBS        = 2;
   localparam int BIT_PULSE_DENS  = 1;

   // Control register field.
   localparam int BIT_B8ZS_EN = 0;

   // Reset values.
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [7:0]  RST_MASK  = 8'h00;

   // Line zero-run and pulse-density limits.
   localparam logic [7:0] LOS_ZERO_RUN      = 8'hC0;
   localparam logic [7:0] PDV_ZERO_RUN      = 8'h10;
   localparam logic [7:0] PDV_ZERO_RUN_B8ZS = 8'h08;
   localparam logic [7:0] AGE_MAX           = 8'hFF;
   localparam int         DENS_ONES_MAX     = 23;
   localparam int         DENS_BITS_PER_N   = 8;

endpackage : tpc_pkg

/* File: sim/tpc_perf_irq_status_bench.sv */
// Self-checking bench for the receive performance counters and event status words.
// Assumes the design drives regRdData only in the cycle after a read strobe.
`timescale 1ns/10ps

module tpc_perf_irq_status_bench;
   logic       ref_clk;
   logic       rstn;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdData;
   logic [2:0] lv;
   logic [9:0] ev;
   logic       fbErr;
   logic       b8Mark;
   logic       anaLos;
   logic       rxBit;
   int         errCount;
   int         compares;
   int         cyc;
   int         w1Bit [4];
   int         lvBit [3];

   tpc_perf_irq_status u_tpc_perf_irq_status (
      .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .frameSyncIn(lv[0]), .mfSyncIn(lv[1]), .allOnesIn(lv[2]),
      .analogLosIn(anaLos), .mfBoundaryIn(ev[8]), .fbitValidIn(ev[7]), .fbitErrIn(fbErr), .bpvIn(ev[6]),
      .bpvB8zsIn(b8Mark), .crcErrIn(ev[0]), .yellowIn(ev[1]), .cofaIn(ev[2]), .prbsErrIn(ev[3]),
      .txSlipIn(ev[4]), .rxSlipIn(ev[5]), .rxBitEnIn(ev[9]), .rxBitIn(rxBit));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task endSim;
      $display("comparisons %0d mismatches %0d", compares, errCount);
      if (errCount == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : endSim

   // One write cycle on the register port.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : wr

   // One read cycle; the answer is compared in the following cycle.
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      compares++;
      if (regRdData !== exp) begin
         errCount++;
         $display("BAD t=%0t addr=%h got=%h exp=%h", $time, a, regRdData, exp);
      end
   endtask : rd

   // One-cycle pulses on an event input, separated by one idle cycle.
   task pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         ev[idx] <= 1'b1;
         @(posedge ref_clk);
         ev[idx] <= 1'b0;
      end
   endtask : pulse

   // A run of n received line bits of one value, one per cycle.
   task bits(input logic v, input int n);
      @(posedge ref_clk);
      rxBit <= v; ev[9] <= 1'b1;
      repeat (n - 1) @(posedge ref_clk);
      @(posedge ref_clk);
      ev[9] <= 1'b0;
   endtask : bits

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         errCount++;
         endSim();
      end
   end

   initial begin
      rstn = 1'b0; regAddr = 8'h00; regWrData = 8'h00; regWr = 1'b0; regRd = 1'b0;
      lv = 3'h0; ev = 10'h000; fbErr = 1'b0; b8Mark = 1'b0; anaLos = 1'b0; rxBit = 1'b0;
      errCount = 0; compares = 0; cyc = 0;
      w1Bit = '{tpc_pkg::BIT_CRC_ERR, tpc_pkg::BIT_YELLOW, tpc_pkg::BIT_ALIGN_SHIFT, tpc_pkg::BIT_PRBS};
      lvBit = '{tpc_pkg::BIT_FRAME_SYNC_CHG, tpc_pkg::BIT_MF_SYNC_CHG, tpc_pkg::BIT_ALL_ONES_CHG};
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(8'h54, 8'h00);
      rd(8'h5C, 8'h00);
      rd(8'h64, 8'h00);
      rd(8'h00, 8'h00);
      $display("done: reset values");
      pulse(0, 1);
      pulse(5, 1);
      rd(8'h70, 8'h00);
      rd(8'h6C, 8'h00);
      wr(8'hAC, 8'hFF);
      wr(8'hB0, 8'hFF);
      rd(8'hAC, 8'hFF);
      wr(8'h64, 8'hFF);
      rd(8'h64, 8'h01);
      $display("done: masking");
      for (int i = 0; i < 4; i++) begin
         pulse(i, 1);
         repeat (4) @(posedge ref_clk);
         rd(8'h70, 8'h01 << w1Bit[i]);
         rd(8'h70, 8'h00);
      end
      rd(8'h60, 8'h00);
      rd(8'h64, 8'h02);
      pulse(4, 1);
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_TX_SLIP);
      pulse(5, 1);
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_RX_SLIP);
      rd(8'h6C, 8'h00);
      fork
         pulse(4, 1);
         rd(8'h6C, 8'h00);
      join
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_TX_SLIP);
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         lv[i] <= 1'b1;
         rd(8'h6C, 8'h01 << lvBit[i]);
         rd(8'h6C, 8'h00);
      end
      $display("done: event flags");
      @(posedge ref_clk);
      b8Mark <= 1'b1;
      pulse(6, 1);
      @(posedge ref_clk);
      b8Mark <= 1'b0;
      rd(8'h70, 8'h00);
      rd(8'h5C, 8'h00);
      pulse(6, 3);
      rd(8'h70, 8'h01 << tpc_pkg::BIT_BIPOLAR);
      rd(8'h5C, 8'h03);
      pulse(6, 253);
      rd(8'h58, 8'h01);
      rd(8'h5C, 8'h00);
      rd(8'h70, 8'h01 << tpc_pkg::BIT_BIPOLAR);
      $display("done: bipolar counter");
      @(posedge ref_clk);
      fbErr <= 1'b1;
      pulse(7, 1);
      rd(8'h70, 8'h01 << tpc_pkg::BIT_FBIT_ERR);
      rd(8'h6C, 8'h00);
      pulse(7, 1);
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_SEVERE_FRAME);
      rd(8'h70, 8'h01 << tpc_pkg::BIT_FBIT_ERR);
      @(posedge ref_clk);
      lv[0] <= 1'b0;
      pulse(7, 1);
      rd(8'h70, 8'h00);
      $display("done: framing errors");
      pulse(8, 1);
      rd(8'h54, 8'h01);
      pulse(8, 255);
      rd(8'h54, 8'h00);
      rd(8'h6C, 8'h84);
      $display("done: multiframe counter");
      bits(1'b0, 15);
      rd(8'h70, 8'h00);
      bits(1'b0, 1);
      rd(8'h70, 8'h01 << tpc_pkg::BIT_PULSE_DENS);
      bits(1'b0, 176);
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_SIGNAL_LOSS);
      bits(1'b1, 1);
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_SIGNAL_LOSS);
      rd(8'h70, 8'h01 << tpc_pkg::BIT_PULSE_DENS);
      wr(8'hB4, 8'hFF);
      rd(8'hB4, 8'h01);
      bits(1'b0, 7);
      rd(8'h70, 8'h00);
      bits(1'b0, 1);
      rd(8'h70, 8'h01 << tpc_pkg::BIT_PULSE_DENS);
      @(posedge ref_clk);
      anaLos <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_SIGNAL_LOSS);
      @(posedge ref_clk);
      anaLos <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd(8'h6C, 8'h01 << tpc_pkg::BIT_SIGNAL_LOSS);
      $display("done: line density and signal loss");
      endSim();
   end
endmodule : tpc_perf_irq_status_bench
